/* File: tnc_dev.sv */
/*
  Node command decoder: parameter and command registers, configuration.
  Assumes network engine inputs on pclk; eval_mode is an asynchronous strap.
*/
`include "tnc_defines.svh"

module tnc_dev #(
  parameter int EXEC_CYCLES = `TNC_EXEC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  tnc_if.dev link,
  input wire logic eval_mode,
  input wire logic nak_seq,
  input wire logic tx_start,
  input wire logic tx_active,
  output logic [7:0] node_identifier,
  output logic [3:0] retry_exp,
  output logic auto_abort,
  output logic [3:0] line_speed,
  output logic [7:0] filter_mask,
  output logic broadcast_rx_en,
  output logic tx_enable,
  output logic proto_reset,
  output logic tx_abort,
  output logic packet_aborted_status
);

  // Refuse execution times the counter cannot hold
  if (EXEC_CYCLES < 1 || EXEC_CYCLES > 15)
  begin : g_bad_exec
    $error("EXEC_CYCLES must be 1 to 15");
  end

  localparam logic [3:0] EXEC_LAST = 4'(EXEC_CYCLES - 1);

  // All state of the decoder
  typedef struct packed {
    tnc_pkg::tnc_state_t st; // Execution state
    logic [3:0] cnt; // Execution cycles left
    logic [7:0] code; // Latched command code
    logic [7:0] par; // Parameter register
    logic [7:0] cmd; // Command register read value
    logic [7:0] node_id; // Node identifier
    logic [3:0] rexp; // Retry exponent
    logic aabort; // Auto-abort enable
    logic [3:0] speed; // Line speed selector
    logic [7:0] filt; // Message filter mask
    logic bcast; // Broadcast reception
    logic txen; // Transmitter enable
    logic preset; // Protocol reset pulse
    logic [15:0] naks; // Retry sequences counted
    logic excessive_negative_ack; // Sticky excessive retry flag
    logic abort; // Transmit abort pulse
    logic pgabort; // Packet aborted status
    logic [1:0] evs; // Strap synchroniser
  } tnc_dev_state_t;

  tnc_dev_state_t cur_ff;
  tnc_dev_state_t nxt_cur;

  // Threshold as two to the exponent, one when retries are off
  function automatic logic [15:0] tnc_limit(input logic [3:0] e);
    tnc_limit = 16'h0001 << e;
  endfunction : tnc_limit

  // Next-state logic
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.preset = 1'b0;
    nxt_cur.abort = 1'b0;
    // Strap sync, only the second stage is read
    nxt_cur.evs = {cur_ff.evs[0], eval_mode};
    // Evaluation mode pins the identifier
    if (cur_ff.evs[1])
      nxt_cur.node_id = `TNC_EVAL_NODE_ID;
    // Host write handling
    case (cur_ff.st)
      tnc_pkg::TNC_IDLE:
      begin
        // Parameter stored ahead of its command
        if (link.par_wr)
          nxt_cur.par = link.wdata;
        // Command write starts execution
        if (link.cmd_wr)
        begin
          nxt_cur.code = link.wdata;
          nxt_cur.cmd = `TNC_CMD_BUSY;
          nxt_cur.cnt = EXEC_LAST;
          nxt_cur.st = tnc_pkg::TNC_BUSY;
        end
      end
      tnc_pkg::TNC_BUSY:
      begin
        // Writes are dropped until done
        if (cur_ff.cnt != 4'h0)
          nxt_cur.cnt = cur_ff.cnt - 4'h1;
        else
        begin
          nxt_cur.st = tnc_pkg::TNC_IDLE;
          nxt_cur.cmd = cur_ff.code;
          case (cur_ff.code)
            `TNC_CMD_SET_NODE_ID:
            begin
              // Zero is not a valid identifier
              if (!cur_ff.evs[1] && cur_ff.par != 8'h00)
                nxt_cur.node_id = cur_ff.par;
            end
            `TNC_CMD_SET_RETRY:
            begin
              nxt_cur.rexp = cur_ff.par[`TNC_RETRY_EXP_MSB:0];
              nxt_cur.aabort = cur_ff.par[`TNC_RETRY_ABORT_BIT];
            end
            `TNC_CMD_SET_SPEED:
            begin
              // Out of range selectors are dropped
              if (cur_ff.par <= {4'h0, `TNC_MAX_SPEED})
              begin
                nxt_cur.speed = cur_ff.par[3:0];
                nxt_cur.preset = 1'b1;
              end
            end
            `TNC_CMD_SET_FILTER:
              nxt_cur.filt = cur_ff.par;
            `TNC_CMD_READ_SETTING:
            begin
              // Answer replaces the selector
              case (cur_ff.par)
                `TNC_SEL_NODE_ID: nxt_cur.par = cur_ff.node_id;
                `TNC_SEL_RETRY: nxt_cur.par = {3'h0, cur_ff.aabort, cur_ff.rexp};
                `TNC_SEL_SPEED: nxt_cur.par = {4'h0, cur_ff.speed};
                `TNC_SEL_FILTER: nxt_cur.par = cur_ff.filt;
                `TNC_SEL_FLAGS: nxt_cur.par = {6'h00, cur_ff.bcast, cur_ff.txen};
                default: nxt_cur.par = 8'h00;
              endcase
            end
            `TNC_CMD_TX_OFF:
            begin
              // Settings stay, transfers are cancelled
              nxt_cur.txen = 1'b0;
              nxt_cur.abort = tx_active;
            end
            `TNC_CMD_TX_ON:
              nxt_cur.txen = 1'b1;
            `TNC_CMD_BCAST_ON:
              nxt_cur.bcast = 1'b1;
            `TNC_CMD_BCAST_OFF:
              nxt_cur.bcast = 1'b0;
            default:
            begin
              // Unknown code only completes
              nxt_cur.code = cur_ff.code;
            end
          endcase
        end
      end
      default:
        nxt_cur.st = tnc_pkg::TNC_IDLE;
    endcase
    // Retry sequence counting restarts with each packet
    if (tx_start)
      nxt_cur.naks = 16'h0000;
    else if (nak_seq)
    begin
      nxt_cur.naks = cur_ff.naks + 16'h0001;
      // Threshold reached
      if (cur_ff.naks + 16'h0001 == tnc_limit(cur_ff.rexp))
      begin
        nxt_cur.excessive_negative_ack = 1'b1;
        // Abort only with auto-abort set
        if (cur_ff.aabort && tx_active)
        begin
          nxt_cur.abort = 1'b1;
          nxt_cur.pgabort = 1'b1;
        end
      end
    end
    // Host clear loses to a same-cycle set
    if (link.excessive_negative_ack_clr && !nxt_cur.excessive_negative_ack)
      nxt_cur.excessive_negative_ack = 1'b0;
    else if (link.excessive_negative_ack_clr && !(nak_seq && !tx_start
             && cur_ff.naks + 16'h0001 == tnc_limit(cur_ff.rexp)))
      nxt_cur.excessive_negative_ack = 1'b0;
    // New packet clears aborted status
    if (tx_start)
      nxt_cur.pgabort = 1'b0;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_ff <= '0;
      cur_ff.st <= tnc_pkg::TNC_IDLE;
      cur_ff.rexp <= `TNC_RST_RETRY_EXP;
      cur_ff.aabort <= 1'b0;
      cur_ff.filt <= `TNC_RST_FILTER;
      cur_ff.speed <= `TNC_RST_SPEED;
      cur_ff.bcast <= 1'b0;
    end
    else
      cur_ff <= nxt_cur;
  end

  // Outputs straight from the state register
  assign link.par_rd = cur_ff.par;
  assign link.cmd_rd = cur_ff.cmd;
  assign link.excessive_negative_ack_flag = cur_ff.excessive_negative_ack;
  assign node_identifier = cur_ff.node_id;
  assign retry_exp = cur_ff.rexp;
  assign auto_abort = cur_ff.aabort;
  assign line_speed = cur_ff.speed;
  assign filter_mask = cur_ff.filt;
  assign broadcast_rx_en = cur_ff.bcast;
  assign tx_enable = cur_ff.txen;
  assign proto_reset = cur_ff.preset;
  assign tx_abort = cur_ff.abort;
  assign packet_aborted_status = cur_ff.pgabort;

endmodule : tnc_dev

/* File: tnc_defines.svh */
/*
  Constants of the node command decoder: command codes, resets, offsets.
  Assumes inclusion by bare name from the package and both ends.
*/
`ifndef TNC_DEFINES_SVH
`define TNC_DEFINES_SVH

// Command codes
`define TNC_CMD_SET_NODE_ID 8'h01
`define TNC_CMD_SET_RETRY 8'h07
`define TNC_CMD_SET_SPEED 8'h08
`define TNC_CMD_SET_FILTER 8'h0C
`define TNC_CMD_READ_SETTING 8'h29
`define TNC_CMD_TX_OFF 8'h37
`define TNC_CMD_TX_ON 8'h38
`define TNC_CMD_BCAST_ON 8'h42
`define TNC_CMD_BCAST_OFF 8'h43
// Command register answer while busy
`define TNC_CMD_BUSY 8'hFF
// Fixed identifier in evaluation mode
`define TNC_EVAL_NODE_ID 8'h0A
// Reset values and highest line speed selector
`define TNC_RST_RETRY_EXP 4'h7
`define TNC_RST_FILTER 8'h3F
`define TNC_RST_SPEED 4'h0
`define TNC_MAX_SPEED 4'h9
// Retry parameter field positions
`define TNC_RETRY_EXP_MSB 3
`define TNC_RETRY_ABORT_BIT 4
// Default execution time in clocks
`define TNC_EXEC_CYCLES 4
// Read-setting selectors
`define TNC_SEL_NODE_ID 8'h00
`define TNC_SEL_RETRY 8'h01
`define TNC_SEL_SPEED 8'h02
`define TNC_SEL_FILTER 8'h03
`define TNC_SEL_FLAGS 8'h04
// Host APB byte offsets
`define TNC_OFS_PAR 12'h000
`define TNC_OFS_CMD 12'h004
`define TNC_OFS_IRQ_STS 12'h008
`define TNC_OFS_IRQ_CLR 12'h00C
`define TNC_OFS_IRQ_EN 12'h010
// Interrupt status bits
`define TNC_IRQ_DONE 0
`define TNC_IRQ_EXCESSIVE_NEGATIVE_ACK 1

`endif

/* File: tnc_pkg.sv */
/*
  Types used by the decoder end of the node command decoder.
  Assumes tnc_defines.svh is on the include path.
*/
`include "tnc_defines.svh"
package tnc_pkg;
  // Decoder execution state
  typedef enum logic [0:0] {TNC_IDLE, TNC_BUSY} tnc_state_t;
endpackage : tnc_pkg

/* File: tnc_if.sv */
/*
  Link between host controller and node command decoder.
  Assumes one clock shared by both ends; strobes last one cycle.
*/
interface tnc_if;
  logic par_wr; // Parameter write strobe
  logic cmd_wr; // Command write strobe
  logic [7:0] wdata; // Data for either strobe
  logic [7:0] par_rd; // Parameter register contents
  logic [7:0] cmd_rd; // Command register contents
  logic excessive_negative_ack_flag; // Sticky excessive retry flag
  logic excessive_negative_ack_clr; // Clear strobe for that flag
  // Decoder end
  modport dev (input par_wr, cmd_wr, wdata, excessive_negative_ack_clr, output par_rd, cmd_rd, excessive_negative_ack_flag);
  // Host end
  modport host (output par_wr, cmd_wr, wdata, excessive_negative_ack_clr, input par_rd, cmd_rd, excessive_negative_ack_flag);
endinterface : tnc_if

/* File: tnc_host.sv */
/*
  Host end: APB slave that forwards parameter and command writes.
  Assumes one pclk shared with the decoder and an APB master outside.
*/
`include "tnc_defines.svh"
module tnc_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  tnc_if.host link
);

  // All state of the host end
  typedef struct packed {
    logic rdy; // Access phase ready
    logic [31:0] rdata; // Read data
    logic err; // Unmapped address
    logic par_wr; // Parameter strobe
    logic cmd_wr; // Command strobe
    logic [7:0] wdata; // Strobe data
    logic clr; // Retry flag clear strobe
    logic [1:0] sts; // Sticky interrupt status
    logic [1:0] en; // Interrupt enables
    logic busy_d; // Command busy last cycle
    logic exn_d; // Retry flag last cycle
    logic irq; // Interrupt output
  } tnc_host_state_t;

  tnc_host_state_t cur_ff;
  tnc_host_state_t nxt_cur;

  // Next-state logic
  always_comb
  begin
    logic setup;
    logic [1:0] ev;
    setup = psel && !penable;
    ev = 2'b00;
    nxt_cur = cur_ff;
    nxt_cur.par_wr = 1'b0;
    nxt_cur.cmd_wr = 1'b0;
    nxt_cur.clr = 1'b0;
    // Ready rises for the access phase, falls after it
    nxt_cur.rdy = setup;
    nxt_cur.err = 1'b0;
    // Completion and flag rising edges
    nxt_cur.busy_d = (link.cmd_rd == `TNC_CMD_BUSY);
    nxt_cur.exn_d = link.excessive_negative_ack_flag;
    ev[`TNC_IRQ_DONE] = cur_ff.busy_d && link.cmd_rd != `TNC_CMD_BUSY;
    ev[`TNC_IRQ_EXCESSIVE_NEGATIVE_ACK] = link.excessive_negative_ack_flag && !cur_ff.exn_d;
    // Decode in the setup cycle
    if (setup)
    begin
      nxt_cur.rdata = 32'h0000_0000;
      case (paddr)
        `TNC_OFS_PAR:
          if (pwrite)
          begin
            nxt_cur.par_wr = 1'b1;
            nxt_cur.wdata = pwdata[7:0];
          end
          else
            nxt_cur.rdata = {24'h00_0000, link.par_rd};
        `TNC_OFS_CMD:
          if (pwrite)
          begin
            nxt_cur.cmd_wr = 1'b1;
            nxt_cur.wdata = pwdata[7:0];
          end
          else
            nxt_cur.rdata = {24'h00_0000, link.cmd_rd};
        `TNC_OFS_IRQ_STS:
          nxt_cur.rdata = {30'h0000_0000, cur_ff.sts};
        `TNC_OFS_IRQ_CLR:
          if (pwrite)
          begin
            nxt_cur.sts = cur_ff.sts & ~pwdata[1:0];
            nxt_cur.clr = pwdata[`TNC_IRQ_EXCESSIVE_NEGATIVE_ACK];
          end
        `TNC_OFS_IRQ_EN:
          if (pwrite)
            nxt_cur.en = pwdata[1:0];
          else
            nxt_cur.rdata = {30'h0000_0000, cur_ff.en};
        default:
          nxt_cur.err = 1'b1;
      endcase
    end
    // Events win over a same-cycle clear
    nxt_cur.sts = nxt_cur.sts | ev;
    nxt_cur.irq = |(nxt_cur.sts & nxt_cur.en);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  // Outputs straight from the state register
  assign prdata = cur_ff.rdata;
  assign pready = cur_ff.rdy;
  assign pslverr = cur_ff.err;
  assign irq = cur_ff.irq;
  assign link.par_wr = cur_ff.par_wr;
  assign link.cmd_wr = cur_ff.cmd_wr;
  assign link.wdata = cur_ff.wdata;
  assign link.excessive_negative_ack_clr = cur_ff.clr;

endmodule : tnc_host

/* File: tnc_link_sva.sv */
/* Checker of the link between host end and command decoder.
   Takes the link signals as plain inputs; instantiated by the bench. */
module tnc_link_sva #(
  parameter int EXEC_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic par_wr,
  input wire logic cmd_wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] par_rd,
  input wire logic [7:0] cmd_rd,
  input wire logic excessive_negative_ack_flag,
  input wire logic excessive_negative_ack_clr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic busy; // Command in progress
  logic [3:0] cnt_ff; // Busy cycles seen so far
  logic [7:0] code_ff; // Last accepted command code
  assign busy = (cmd_rd == 8'hFF);
  // Count busy cycles and keep the accepted code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 4'h0;
      code_ff <= 8'h00;
    end
    else
    begin
      cnt_ff <= busy ? cnt_ff + 4'h1 : 4'h0;
      if (cmd_wr && !busy)
        code_ff <= wdata;
    end
  end
  sequence s_start;
    cmd_wr && !busy;
  endsequence
  sequence s_done;
    $past(busy) && !busy;
  endsequence
  property p_start;
    s_start |=> busy;
  endproperty
  a_start: assert property (p_start) else $error("busy code missing");
  property p_hold;
    busy |-> cnt_ff < EXEC_CYCLES;
  endproperty
  a_hold: assert property (p_hold) else $error("busy too long");
  property p_len;
    s_done |-> cnt_ff == EXEC_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("busy too short");
  property p_echo;
    s_done |-> cmd_rd == code_ff;
  endproperty
  a_echo: assert property (p_echo) else $error("wrong code echoed");
  property p_par;
    par_wr && !busy |=> par_rd == $past(wdata);
  endproperty
  a_par: assert property (p_par) else $error("parameter not kept");
  property p_par_busy;
    par_wr && busy && cnt_ff < EXEC_CYCLES - 1 |=> $stable(par_rd);
  endproperty
  a_par_busy: assert property (p_par_busy) else $error("busy write taken");
  property p_sticky;
    excessive_negative_ack_flag && !excessive_negative_ack_clr |=> excessive_negative_ack_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_pulse;
    cmd_wr || par_wr |=> !(cmd_wr || par_wr);
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_excl;
    !(cmd_wr && par_wr);
  endproperty
  a_excl: assert property (p_excl) else $error("two strobes at once");
endmodule : tnc_link_sva

/* File: token_ring_node_command_decoder_tb.sv */
/* Bench of host end and command decoder joined by the link.
   Assumes design files and checker are compiled before it. */
module token_ring_node_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EXEC = 12; // Longer than default execution time
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic eval_mode = 1'b0;
  logic nak_seq = 1'b0;
  logic tx_start = 1'b0;
  logic tx_active = 1'b0;
  logic [7:0] node_identifier, filter_mask;
  logic [3:0] retry_exp, line_speed;
  logic auto_abort, broadcast_rx_en, tx_enable, proto_reset, tx_abort, packet_aborted_status;
  int num_errors = 0;
  int cmp_count = 0;
  int pr_cnt = 0; // Speed reset pulses
  int ab_cnt = 0; // Abort pulses
  logic [31:0] rd; // Last read data
  logic err; // Last error response
  // Expected read-setting answers for selectors 0 to 5
  logic [7:0] exp_set [6] = '{8'h0A, 8'h00, 8'h07, 8'hA5, 8'h00, 8'h00};
  tnc_if tnc_if_i ();
  tnc_host tnc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(tnc_if_i.host));
  tnc_dev #(.EXEC_CYCLES(EXEC)) tnc_dev_i (.pclk(pclk), .presetn(presetn),
    .link(tnc_if_i.dev), .eval_mode(eval_mode), .nak_seq(nak_seq), .tx_start(tx_start),
    .tx_active(tx_active), .node_identifier(node_identifier), .retry_exp(retry_exp),
    .auto_abort(auto_abort), .line_speed(line_speed), .filter_mask(filter_mask),
    .broadcast_rx_en(broadcast_rx_en), .tx_enable(tx_enable), .proto_reset(proto_reset),
    .tx_abort(tx_abort), .packet_aborted_status(packet_aborted_status));
  tnc_link_sva #(.EXEC_CYCLES(EXEC)) tnc_link_sva_i (.pclk(pclk), .presetn(presetn),
    .par_wr(tnc_if_i.par_wr), .cmd_wr(tnc_if_i.cmd_wr), .wdata(tnc_if_i.wdata),
    .par_rd(tnc_if_i.par_rd), .cmd_rd(tnc_if_i.cmd_rd), .excessive_negative_ack_flag(tnc_if_i.excessive_negative_ack_flag),
    .excessive_negative_ack_clr(tnc_if_i.excessive_negative_ack_clr));
  // Clock of 8 ns
  always #4 pclk = ~pclk;
  // Count one-cycle pulses of the decoder
  always @(posedge pclk)
  begin
    if (proto_reset === 1'b1)
      pr_cnt++;
    if (tx_abort === 1'b1)
      ab_cnt++;
  end
  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll the command register until done
  task automatic wait_done(input logic [7:0] c);
    rd = 32'h0000_00FF;
    while (rd[7:0] === 8'hFF)
      apb(1'b0, 12'h004, 32'h0000_0000);
    check(rd, {24'h00_0000, c});
  endtask : wait_done
  // Parameter, then command, then completion
  task automatic cmd(input logic [7:0] p, input logic [7:0] c);
    apb(1'b1, 12'h000, {24'h00_0000, p});
    apb(1'b1, 12'h004, {24'h00_0000, c});
    wait_done(c);
  endtask : cmd
  // One pulse on the retry event input
  task automatic nak();
    @(posedge pclk);
    nak_seq <= 1'b1;
    @(posedge pclk);
    nak_seq <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : nak
  // New packet starts
  task automatic start_tx();
    @(posedge pclk);
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
  endtask : start_tx
  // Verdict and end of run
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check({node_identifier, retry_exp, auto_abort, line_speed, filter_mask, broadcast_rx_en,
      tx_enable}, {8'h00, 4'h7, 1'b0, 4'h0, 8'h3F, 2'b00});
    // Writes while busy are dropped
    apb(1'b1, 12'h000, 32'h0000_0055);
    apb(1'b1, 12'h004, 32'h0000_0001);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check(rd, 32'h0000_00FF);
    apb(1'b1, 12'h000, 32'h0000_0099);
    apb(1'b1, 12'h004, 32'h0000_0043);
    wait_done(8'h01);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check({rd[7:0], node_identifier}, 16'h5555);
    eval_mode <= 1'b1;
    cmd(8'h33, 8'h01);
    check(node_identifier, 8'h0A);
    eval_mode <= 1'b0;
    // Retry limit 4 with auto-abort
    apb(1'b1, 12'h010, 32'h0000_0002);
    cmd(8'h12, 8'h07);
    check({auto_abort, retry_exp}, 5'h12);
    tx_active <= 1'b1;
    start_tx();
    repeat (3) nak();
    check({irq, packet_aborted_status}, 2'b00);
    nak();
    check({irq, packet_aborted_status, ab_cnt}, 34'h3_0000_0001);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check(rd[1:0], 2'b11);
    apb(1'b1, 12'h00C, 32'h0000_0003);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check({irq, rd[1:0]}, 3'b000);
    // No retries, no abort, event masked
    apb(1'b1, 12'h010, 32'h0000_0000);
    cmd(8'h00, 8'h07);
    start_tx();
    nak();
    apb(1'b0, 12'h008, 32'h0000_0000);
    check({irq, packet_aborted_status, rd[1], ab_cnt}, 35'h1_0000_0001);
    // Line speed, out of range ignored
    cmd(8'h07, 8'h08);
    cmd(8'h0A, 8'h08);
    check({line_speed, pr_cnt}, 36'h7_0000_0001);
    cmd(8'hA5, 8'h0C);
    check(filter_mask, 8'hA5);
    // Every selector, and one past them
    for (int i = 0; i < 6; i++)
    begin
      cmd(i[7:0], 8'h29);
      apb(1'b0, 12'h000, 32'h0000_0000);
      check(rd, {24'h00_0000, exp_set[i]});
    end
    cmd(8'h00, 8'h38);
    cmd(8'h00, 8'h42);
    check({tx_enable, broadcast_rx_en}, 2'b11);
    cmd(8'h00, 8'h37);
    cmd(8'h00, 8'h43);
    cmd(8'h00, 8'h5A);
    check({tx_enable, broadcast_rx_en, filter_mask, line_speed}, 14'h0A57);
    check(ab_cnt, 2);
    apb(1'b0, 12'h100, 32'h0000_0000);
    check(err, 1'b1);
    finish_test();
  end
endmodule : token_ring_node_command_decoder_tb
